// ==== src/ccc_params.svh ====
// Offsets, field positions, reset values and timing figures of the
// charge-cycle controller. Assumes a 200 MHz clock.
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// Register offsets (4-bit address, 8-bit data)
`define CCC_ADDR_CTRL 4'h0
`define CCC_ADDR_FAST_CHARGE_CURRENT_SETTING 4'h1
`define CCC_ADDR_IPRE 4'h2
`define CCC_ADDR_ITERM 4'h3
`define CCC_ADDR_VREG 4'h4
`define CCC_ADDR_TIMER 4'h5
`define CCC_ADDR_MON 4'h6
`define CCC_ADDR_STATUS 4'h7

// Control register fields
`define CCC_CTRL_CHG_EN 0
`define CCC_CTRL_TERM_EN 1
`define CCC_CTRL_TMR_EN 2
`define CCC_CTRL_SLOW_EN 3
`define CCC_CTRL_SW_OFF 4
`define CCC_CTRL_IND_DIS 5
`define CCC_CTRL_RECHG_SEL 6

// Monitor register fields
`define CCC_MON_CONT 0
`define CCC_MON_GO 1

// Reset values
`define CCC_CTRL_RST 8'h0E
`define CCC_FAST_CHARGE_CURRENT_SETTING_RST 7'h00
`define CCC_IPRE_RST 4'h0
// 256 mA at 64 mA per step
`define CCC_ITERM_RST 4'h4
// 4.208 V as (4.208 V - 3.840 V) / 16 mV
`define CCC_VREG_RST 6'h17
// Fast-charge timeout code 2'h2 selects 12 hours
`define CCC_TIMER_RST 2'h2
`define CCC_UNMAPPED_DATA 8'h00

// Timing
`define CCC_CLK_MHZ 200
`define CCC_CLK_KHZ 200000
`define CCC_PULSE_US 256
`define CCC_BLINK_HALF_MS 500
`define CCC_SECOND_MS 1000
`define CCC_CONV_MAX_MS 1000

// Safety timeouts in seconds, low-battery limit in hours
`define CCC_LOWBAT_HOURS 4
`define CCC_TMO_SEC_0 17'd18000
`define CCC_TMO_SEC_1 17'd28800
`define CCC_TMO_SEC_2 17'd43200
`define CCC_TMO_SEC_3 17'd72000

`endif

// ==== src/ccc_pkg.sv ====
// Types of the charge-cycle controller.
// Constants live in ccc_params.svh.
package ccc_pkg;

    typedef enum logic [1:0] {
        PH_DISABLED = 2'b00,
        PH_PRECHARGE = 2'b01,
        PH_FAST = 2'b10,
        PH_DONE = 2'b11
    } ccc_phase_type;

    typedef enum logic [1:0] {
        CUR_NONE = 2'b00,
        CUR_SHORT = 2'b01,
        CUR_PRE = 2'b10,
        CUR_FAST = 2'b11
    } ccc_cursel_type;

    typedef enum logic [1:0] {
        FLT_NONE = 2'b00,
        FLT_TIMER = 2'b11
    } ccc_fault_type;

endpackage

// ==== src/ccc_charge_ctrl.sv ====
// Charge-cycle controller: phase selection, termination, recharge,
// safety timer, status indicator, host event pulse, monitor sequencing.
// Assumes analogue comparator levels arrive unsynchronised on pins and a
// plain register port driven from the clk domain.
`timescale 1ns/100ps
`include "ccc_params.svh"

module ccc_charge_ctrl
    import ccc_pkg::*;
#(
    parameter int PULSE_CYCLES = `CCC_PULSE_US * `CCC_CLK_MHZ,
    parameter int BLINK_CYCLES = `CCC_BLINK_HALF_MS * `CCC_CLK_KHZ,
    parameter int SEC_CYCLES = `CCC_SECOND_MS * `CCC_CLK_KHZ,
    parameter int CONV_CYCLES = `CCC_CONV_MAX_MS * `CCC_CLK_KHZ
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Pins and comparator levels, asynchronous
    input wire logic chargeAllowN,
    input wire logic converterOn,
    input wire logic inputPresent,
    input wire logic batBelowShort,
    input wire logic batBelowLow,
    input wire logic currentBelowTerm,
    input wire logic batAboveRechgLo,
    input wire logic batAboveRechgHi,
    input wire logic inputPowerLimiting,
    input wire logic thermalRegulation,
    input wire logic suspendFault,
    // Charge control
    output ccc_cursel_type currentSelect,
    output logic batterySwitchOn,
    output logic [6:0] fastChargeCurrentSetting,
    output logic [3:0] prechargeCurrentSetting,
    output logic [3:0] termCurrentSetting,
    output logic [5:0] chargeVoltageSetting,
    // Indicator, open drain, enable low while pulling low
    output logic indicatorOut,
    output logic indicatorOeN,
    // Host event, one pulse of PULSE_CYCLES
    output logic hostEvent,
    // Monitor sequencing
    output logic monitorActive,
    output logic [3:0] monitorSample
);

    // Synchroniser, first stage read only by the second
    logic [10:0] syncA;
    logic [10:0] syncB;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            syncA <= 11'h001;
            syncB <= 11'h001;
        end else if (clkEn) begin
            syncA <= {converterOn, inputPresent, batBelowShort, batBelowLow,
                      currentBelowTerm, batAboveRechgLo, batAboveRechgHi,
                      inputPowerLimiting, thermalRegulation, suspendFault,
                      chargeAllowN};
            syncB <= syncA;
        end
    end

    logic convOn, inPresent, belowShort, belowLow, lowCurrent;
    logic aboveLo, aboveHi, limiting, thermal, suspend, allowN;
    assign {convOn, inPresent, belowShort, belowLow, lowCurrent, aboveLo,
            aboveHi, limiting, thermal, suspend, allowN} = syncB;

    // Registers
    logic [7:0] ctrl;
    logic [1:0] timeoutSelect;
    logic monitorContinuousSelect;
    logic convBusy;
    ccc_phase_type phase;
    ccc_fault_type chargeFault;

    logic chgEn, termEn, tmrEn, slowEn, swOff, indDis, rechgSel;
    assign chgEn = ctrl[`CCC_CTRL_CHG_EN];
    assign termEn = ctrl[`CCC_CTRL_TERM_EN];
    assign tmrEn = ctrl[`CCC_CTRL_TMR_EN];
    assign slowEn = ctrl[`CCC_CTRL_SLOW_EN];
    assign swOff = ctrl[`CCC_CTRL_SW_OFF];
    assign indDis = ctrl[`CCC_CTRL_IND_DIS];
    assign rechgSel = ctrl[`CCC_CTRL_RECHG_SEL];

    logic wrMon, rdStatus;
    assign wrMon = clkEn && regWr && regAddr == `CCC_ADDR_MON;
    assign rdStatus = clkEn && regRd && regAddr == `CCC_ADDR_STATUS;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= `CCC_CTRL_RST;
            fastChargeCurrentSetting <= `CCC_FAST_CHARGE_CURRENT_SETTING_RST;
            prechargeCurrentSetting <= `CCC_IPRE_RST;
            termCurrentSetting <= `CCC_ITERM_RST;
            chargeVoltageSetting <= `CCC_VREG_RST;
            timeoutSelect <= `CCC_TIMER_RST;
            monitorContinuousSelect <= 1'b0;
        end else if (clkEn && regWr) begin
            case (regAddr)
                `CCC_ADDR_CTRL: ctrl <= {1'b0, regWrData[6:0]};
                `CCC_ADDR_FAST_CHARGE_CURRENT_SETTING: fastChargeCurrentSetting <= regWrData[6:0];
                `CCC_ADDR_IPRE: prechargeCurrentSetting <= regWrData[3:0];
                `CCC_ADDR_ITERM: termCurrentSetting <= regWrData[3:0];
                `CCC_ADDR_VREG: chargeVoltageSetting <= regWrData[5:0];
                `CCC_ADDR_TIMER: timeoutSelect <= regWrData[1:0];
                `CCC_ADDR_MON: begin
                    monitorContinuousSelect <= regWrData[`CCC_MON_CONT];
                end
                default: ;
            endcase
        end
    end

    // Charge enable from bit, pin and current setting
    logic chargeEnabled;
    assign chargeEnabled = chgEn && !allowN
                           && fastChargeCurrentSetting != 7'h00;

    logic startOk;
    assign startOk = convOn && chargeEnabled
                     && chargeFault == FLT_NONE && !swOff;

    logic rechgAbove;
    assign rechgAbove = rechgSel ? aboveHi : aboveLo;

    logic regulating;
    assign regulating = limiting || thermal;

    logic charging;
    assign charging = phase == PH_PRECHARGE || phase == PH_FAST;

    logic terminate;
    assign terminate = phase == PH_FAST && lowCurrent && rechgAbove
                       && !regulating && termEn;

    function automatic ccc_phase_type phaseFor(input logic lowBat);
        phaseFor = lowBat ? PH_PRECHARGE : PH_FAST;
    endfunction

    function automatic logic [16:0] timeoutSec(input logic lowBat,
                                               input logic [1:0] sel);
        if (lowBat) begin
            timeoutSec = 17'(`CCC_LOWBAT_HOURS * 3600);
        end else begin
            case (sel)
                2'h0: timeoutSec = `CCC_TMO_SEC_0;
                2'h1: timeoutSec = `CCC_TMO_SEC_1;
                2'h2: timeoutSec = `CCC_TMO_SEC_2;
                default: timeoutSec = `CCC_TMO_SEC_3;
            endcase
        end
    endfunction

    // One-second tick shared by timer and monitor
    logic [27:0] secCnt;
    logic secTick;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            secCnt <= 28'h0000000;
            secTick <= 1'b0;
        end else if (clkEn) begin
            secTick <= secCnt == 28'(SEC_CYCLES - 1);
            if (secCnt == 28'(SEC_CYCLES - 1)) begin
                secCnt <= 28'h0000000;
            end else begin
                secCnt <= secCnt + 28'h0000001;
            end
        end
    end

    // Safety timer
    logic [16:0] tmrSec;
    logic halfPhase;
    logic timerExpire;
    logic tmrRestart;
    ccc_phase_type next_phase;

    assign timerExpire = charging && tmrEn
                         && tmrSec >= timeoutSec(belowLow, timeoutSelect);

    assign tmrRestart = next_phase != phase;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tmrSec <= 17'h00000;
            halfPhase <= 1'b0;
        end else if (clkEn) begin
            if (tmrRestart || !tmrEn || !charging) begin
                tmrSec <= 17'h00000;
                halfPhase <= 1'b0;
            end else if (secTick) begin
                halfPhase <= !halfPhase;
                // Half rate only counts every second tick
                if (!(slowEn && regulating) || halfPhase) begin
                    tmrSec <= tmrSec + 17'h00001;
                end
            end
        end
    end

    // Charge phase machine
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_DISABLED: begin
                if (startOk) begin
                    next_phase = phaseFor(belowLow);
                end
            end
            PH_PRECHARGE, PH_FAST: begin
                if (!chargeEnabled || swOff || !convOn) begin
                    next_phase = PH_DISABLED;
                end else if (timerExpire) begin
                    next_phase = PH_DISABLED;
                end else if (terminate) begin
                    next_phase = PH_DONE;
                end else begin
                    next_phase = phaseFor(belowLow);
                end
            end
            PH_DONE: begin
                // Dropping enable returns to idle, so a toggle restarts
                if (!chargeEnabled || swOff || !convOn) begin
                    next_phase = PH_DISABLED;
                end else if (!rechgAbove) begin
                    next_phase = phaseFor(belowLow);
                end
            end
            default: next_phase = PH_DISABLED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= PH_DISABLED;
        end else if (clkEn) begin
            phase <= next_phase;
        end
    end

    // Fault field, clear on status read, a new expiry wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            chargeFault <= FLT_NONE;
        end else if (clkEn) begin
            if (timerExpire) begin
                chargeFault <= FLT_TIMER;
            end else if (rdStatus) begin
                chargeFault <= FLT_NONE;
            end
        end
    end

    // Charge path outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            currentSelect <= CUR_NONE;
            batterySwitchOn <= 1'b0;
        end else if (clkEn) begin
            if (!charging) begin
                currentSelect <= CUR_NONE;
            end else if (belowShort) begin
                currentSelect <= CUR_SHORT;
            end else if (belowLow) begin
                currentSelect <= CUR_PRE;
            end else begin
                currentSelect <= CUR_FAST;
            end
            // Odd parity marks precharge and fast; opens on the done edge
            batterySwitchOn <= (^next_phase) && !swOff;
        end
    end

    // Host event pulse
    logic [15:0] pulseCnt;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pulseCnt <= 16'h0000;
            hostEvent <= 1'b0;
        end else if (clkEn) begin
            if ((charging && next_phase == PH_DONE) || timerExpire) begin
                pulseCnt <= 16'(PULSE_CYCLES - 1);
                hostEvent <= 1'b1;
            end else if (pulseCnt != 16'h0000) begin
                pulseCnt <= pulseCnt - 16'h0001;
            end else begin
                hostEvent <= 1'b0;
            end
        end
    end

    // Indicator with 1 Hz blink
    logic [26:0] blinkCnt;
    logic blinkLevel;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            blinkCnt <= 27'h0000000;
            blinkLevel <= 1'b0;
        end else if (clkEn) begin
            if (blinkCnt == 27'(BLINK_CYCLES - 1)) begin
                blinkCnt <= 27'h0000000;
                blinkLevel <= !blinkLevel;
            end else begin
                blinkCnt <= blinkCnt + 27'h0000001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            indicatorOut <= 1'b0;
            indicatorOeN <= 1'b1;
        end else if (clkEn) begin
            indicatorOut <= 1'b0;
            if (indDis) begin
                indicatorOeN <= 1'b1;
            end else if (suspend || chargeFault != FLT_NONE) begin
                indicatorOeN <= blinkLevel;
            end else begin
                indicatorOeN <= !charging;
            end
        end
    end

    // Battery monitor sequencing
    logic [27:0] convCnt;
    logic convDone;
    assign convDone = convBusy && convCnt == 28'(CONV_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            convBusy <= 1'b0;
            convCnt <= 28'h0000000;
        end else if (clkEn) begin
            if (monitorContinuousSelect) begin
                convBusy <= 1'b1;
                convCnt <= secTick ? 28'h0000000 : convCnt;
            end else if (convDone) begin
                convBusy <= 1'b0;
                convCnt <= 28'h0000000;
            end else if (convBusy) begin
                convCnt <= convCnt + 28'h0000001;
            end else if (wrMon && regWrData[`CCC_MON_GO]
                         && !regWrData[`CCC_MON_CONT]) begin
                convBusy <= 1'b1;
                convCnt <= 28'h0000000;
            end
        end
    end

    // No result before the monitor shows itself active
    logic sampleNow, tickActive;
    assign tickActive = secTick && monitorActive;
    assign sampleNow = monitorContinuousSelect ? tickActive : convDone;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            monitorSample <= 4'h0;
            monitorActive <= 1'b0;
        end else if (clkEn) begin
            monitorActive <= convBusy;
            // Bits: current, input, system, battery
            monitorSample <= sampleNow
                ? {charging, inPresent, 1'b1, 1'b1} : 4'h0;
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            if (regRd) begin
                case (regAddr)
                    `CCC_ADDR_CTRL: regRdData <= ctrl;
                    `CCC_ADDR_FAST_CHARGE_CURRENT_SETTING: regRdData <= {1'b0,
                                                  fastChargeCurrentSetting};
                    `CCC_ADDR_IPRE: regRdData <= {4'h0,
                                                  prechargeCurrentSetting};
                    `CCC_ADDR_ITERM: regRdData <= {4'h0, termCurrentSetting};
                    `CCC_ADDR_VREG: regRdData <= {2'h0, chargeVoltageSetting};
                    `CCC_ADDR_TIMER: regRdData <= {6'h00, timeoutSelect};
                    `CCC_ADDR_MON: regRdData <= {6'h00, convBusy,
                                                 monitorContinuousSelect};
                    `CCC_ADDR_STATUS: regRdData <= {2'h0, inPresent,
                        batterySwitchOn, chargeFault, phase};
                    default: regRdData <= `CCC_UNMAPPED_DATA;
                endcase
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

endmodule

// ==== testbench/ccc_charge_chk.sv ====
// Concurrent checks on the charge-cycle controller ports.
// Assumes clkEn is held high and one clk domain.
`timescale 1ns/100ps
module ccc_charge_chk
    import ccc_pkg::*;
#(
    parameter int PULSE_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    // Charge outputs
    input wire logic batterySwitchOn,
    input wire logic [6:0] fastChargeCurrentSetting,
    input wire logic [3:0] prechargeCurrentSetting,
    input wire logic [3:0] termCurrentSetting,
    input wire logic [5:0] chargeVoltageSetting,
    input wire logic indicatorOut,
    input wire logic hostEvent,
    input wire logic monitorActive,
    input wire logic [3:0] monitorSample
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic [15:0] evCnt;

    // Counts sampled high cycles of the event pulse
    always_ff @(posedge clk) begin
        if (!nrst || !hostEvent) begin
            evCnt <= 16'h0000;
        end else begin
            evCnt <= evCnt + 16'h0001;
        end
    end

    sequence s_sampleSeen;
        ##[1:30] (monitorSample != 4'h0);
    endsequence

    property p_convBound;
        $rose(monitorActive) |-> s_sampleSeen;
    endproperty

    chk_rd_idle_zero: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not zero outside read answer");
    chk_event_width: assert property ($fell(hostEvent) |->
        evCnt == PULSE_CYCLES)
        else $error("host event pulse has wrong length");
    chk_event_switch: assert property ($rose(hostEvent) |->
        !batterySwitchOn)
        else $error("battery switch closed at event");
    chk_ind_data: assert property (indicatorOut == 1'b0)
        else $error("indicator data not low");
    chk_sample_pair: assert property (monitorSample != 4'h0 |->
        monitorSample[1:0] == 2'b11)
        else $error("battery or system sample missing");
    chk_conv_bound: assert property (p_convBound)
        else $error("no conversion result in time");
    chk_sample_active: assert property (monitorSample != 4'h0 |->
        $past(monitorActive))
        else $error("sample without active monitor");
    chk_set_stable: assert property (!$past(regWr) |->
        $stable({fastChargeCurrentSetting, prechargeCurrentSetting,
        termCurrentSetting, chargeVoltageSetting}))
        else $error("setting changed without write");
endmodule

bind ccc_charge_ctrl ccc_charge_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
    .clk(clk), .nrst(nrst), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .batterySwitchOn(batterySwitchOn),
    .fastChargeCurrentSetting(fastChargeCurrentSetting),
    .prechargeCurrentSetting(prechargeCurrentSetting),
    .termCurrentSetting(termCurrentSetting),
    .chargeVoltageSetting(chargeVoltageSetting),
    .indicatorOut(indicatorOut), .hostEvent(hostEvent),
    .monitorActive(monitorActive), .monitorSample(monitorSample)
);

// ==== testbench/ccc_host_model.sv ====
// Host side of the register port: one-cycle write and read strobes.
// Assumes the slave answers a read in the following cycle.
`timescale 1ns/100ps
module ccc_host_model (
    // Clock
    input wire logic clk,
    // Register port toward the controller
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdData;
    endtask
endmodule

// ==== testbench/test_charge_cycle_controller.sv ====
// Self-checking bench for the charge-cycle controller.
// Assumes short timing parameters; the hours-long timer is not run.
`timescale 1ns/100ps
module test_charge_cycle_controller
    import ccc_pkg::*;
;
    logic clk, nrst, clkEn, regWr, regRd, chargeAllowN, converterOn;
    logic inputPresent, batBelowShort, batBelowLow, currentBelowTerm;
    logic batAboveRechgLo, batAboveRechgHi, inputPowerLimiting;
    logic thermalRegulation, suspendFault, batterySwitchOn, indicatorOut;
    logic indicatorOeN, hostEvent, monitorActive;
    logic [3:0] regAddr, monitorSample, pcs, tcs, smp;
    logic [7:0] regWrData, regRdData;
    logic [6:0] fcs;
    logic [5:0] cvs;
    ccc_cursel_type currentSelect;
    int err_count = 0;
    int total_checks = 0;
    logic [7:0] rstVal [10] = '{8'h0E, 8'h00, 8'h00, 8'h04, 8'h17, 8'h02,
        8'h00, 8'h20, 8'h00, 8'h00};

    ccc_host_model host (.clk(clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));

    ccc_charge_ctrl #(.PULSE_CYCLES(8), .BLINK_CYCLES(6), .SEC_CYCLES(20),
        .CONV_CYCLES(10)) DUT (.clk(clk), .nrst(nrst), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .chargeAllowN(chargeAllowN),
        .converterOn(converterOn), .inputPresent(inputPresent),
        .batBelowShort(batBelowShort), .batBelowLow(batBelowLow),
        .currentBelowTerm(currentBelowTerm),
        .batAboveRechgLo(batAboveRechgLo), .batAboveRechgHi(batAboveRechgHi),
        .inputPowerLimiting(inputPowerLimiting),
        .thermalRegulation(thermalRegulation), .suspendFault(suspendFault),
        .currentSelect(currentSelect), .batterySwitchOn(batterySwitchOn),
        .fastChargeCurrentSetting(fcs), .prechargeCurrentSetting(pcs),
        .termCurrentSetting(tcs), .chargeVoltageSetting(cvs),
        .indicatorOut(indicatorOut), .indicatorOeN(indicatorOeN),
        .hostEvent(hostEvent), .monitorActive(monitorActive),
        .monitorSample(monitorSample));

    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [7:0] m, exp);
        logic [7:0] d;
        host.rd(a, d);
        check($sformatf("reg %h", a), d & m, exp);
    endtask

    // Two sync stages plus margin for the reaction
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic waitEvent;
        int n;
        n = 0;
        while (hostEvent !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check("hostEvent", {7'h00, hostEvent}, 8'h01);
    endtask

    task automatic waitSample;
        int n;
        n = 0;
        smp = 4'h0;
        while (smp == 4'h0 && n < 50) begin
            @(posedge clk);
            smp = monitorSample;
            n++;
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("ERROR watchdog expected finish seen hang");
        summarize;
    end

    initial begin
        int tog;
        logic last;
        nrst = 1'b0;
        clkEn = 1'b1;
        chargeAllowN = 1'b0;
        converterOn = 1'b1;
        inputPresent = 1'b1;
        batBelowShort = 1'b1;
        batBelowLow = 1'b1;
        currentBelowTerm = 1'b0;
        batAboveRechgLo = 1'b0;
        batAboveRechgHi = 1'b0;
        inputPowerLimiting = 1'b0;
        thermalRegulation = 1'b0;
        suspendFault = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        host.wr(4'h9, 8'hFF);
        for (int i = 0; i < 10; i++) begin
            rdChk(i[3:0], 8'hFF, rstVal[i]);
        end
        check("vreg", {2'b00, cvs}, 8'h17);
        check("ipre", {4'h0, pcs}, 8'h00);
        check("iterm", {4'h0, tcs}, 8'h04);
        host.wr(4'h0, 8'h8F);
        rdChk(4'h0, 8'hFF, 8'h0F);
        settle;
        rdChk(4'h7, 8'h13, 8'h00);
        host.wr(4'h1, 8'h10);
        settle;
        check("fast_charge_current_setting", {1'b0, fcs}, 8'h10);
        rdChk(4'h7, 8'h13, 8'h11);
        check("cursel", {6'h00, currentSelect}, 8'h01);
        check("indOeN", {7'h00, indicatorOeN}, 8'h00);
        batBelowShort <= 1'b0;
        settle;
        check("cursel", {6'h00, currentSelect}, 8'h02);
        batBelowLow <= 1'b0;
        settle;
        rdChk(4'h7, 8'h13, 8'h12);
        check("cursel", {6'h00, currentSelect}, 8'h03);
        currentBelowTerm <= 1'b1;
        batAboveRechgLo <= 1'b1;
        inputPowerLimiting <= 1'b1;
        settle;
        rdChk(4'h7, 8'h03, 8'h02);
        inputPowerLimiting <= 1'b0;
        thermalRegulation <= 1'b1;
        host.wr(4'h0, 8'h0D);
        settle;
        rdChk(4'h7, 8'h03, 8'h02);
        thermalRegulation <= 1'b0;
        settle;
        rdChk(4'h7, 8'h03, 8'h02);
        host.wr(4'h0, 8'h0F);
        waitEvent;
        rdChk(4'h7, 8'h13, 8'h03);
        check("indOeN", {7'h00, indicatorOeN}, 8'h01);
        batAboveRechgLo <= 1'b0;
        settle;
        rdChk(4'h7, 8'h13, 8'h12);
        batAboveRechgLo <= 1'b1;
        waitEvent;
        currentBelowTerm <= 1'b0;
        chargeAllowN <= 1'b1;
        settle;
        rdChk(4'h7, 8'h03, 8'h00);
        chargeAllowN <= 1'b0;
        settle;
        rdChk(4'h7, 8'h13, 8'h12);
        host.wr(4'h0, 8'h1E);
        settle;
        host.wr(4'h0, 8'h1F);
        settle;
        rdChk(4'h7, 8'h03, 8'h00);
        host.wr(4'h0, 8'h2F);
        settle;
        rdChk(4'h7, 8'h03, 8'h02);
        check("indOeN", {7'h00, indicatorOeN}, 8'h01);
        host.wr(4'h0, 8'h0F);
        suspendFault <= 1'b1;
        settle;
        tog = 0;
        last = indicatorOeN;
        repeat (30) begin
            @(posedge clk);
            if (indicatorOeN !== last) tog++;
            last = indicatorOeN;
        end
        check("blink", (tog >= 4) ? 8'h01 : 8'h00, 8'h01);
        suspendFault <= 1'b0;
        settle;
        host.wr(4'h6, 8'h02);
        rdChk(4'h6, 8'h02, 8'h02);
        check("monActive", {7'h00, monitorActive}, 8'h01);
        waitSample;
        check("sample", {4'h0, smp}, 8'h0F);
        settle;
        rdChk(4'h6, 8'h02, 8'h00);
        host.wr(4'h6, 8'h01);
        rdChk(4'h6, 8'h03, 8'h03);
        waitSample;
        check("sample", {4'h0, smp}, 8'h0F);
        repeat (2) @(posedge clk);
        waitSample;
        check("sample", {4'h0, smp}, 8'h0F);
        host.wr(4'h6, 8'h00);
        // The conversion in flight still finishes after the mode ends
        settle;
        settle;
        rdChk(4'h6, 8'h03, 8'h00);
        summarize;
    end
endmodule
